// ===== plwd_top.sv
`timescale 1ns/1ps

// Function
// - Reset loads mode 67H, counting starts at once.
// - Second full mode write asserts internal reset.
// - Bits 4:3 select osc, high-speed, or stop.
// - Period n overflows at 2^(11+n) or 2^(13+n).
// - Period field is all ones after reset.
// - Non-stop option ignores clock select, uses osc.
// - Full mode write stalls bus one wait cycle.
// - Violation with stopped source fires on resume.
// - Stop by bit 4 is never undone.
// - Key ACH clears counter and restarts counting.
// - Key register always reads 9AH.
// - Key write other than ACH asserts reset.
// - Bit access to key register asserts reset.
// - Counter overflow asserts internal reset.
// - No violation resets while stopped by bit 4.
// - Non-stop mode counts through STOP and HALT.
// - Accepted mode write clears the counter.
// - Watchdog reset sets the reset cause flag.
// - Stoppable mode pauses in HALT/STOP, keeps count.
module plwd_top (
  input  logic                          mclk,
  input  logic                          arst_n,
  input  logic [plwd_pkg::ADDR_W-1:0]   bus_addr,
  input  logic                          bus_wr,
  input  logic                          bus_rd,
  input  logic                          bus_bit_op,
  input  logic [plwd_pkg::DATA_W-1:0]   bus_wdata,
  output logic [plwd_pkg::DATA_W-1:0]   bus_rdata_r,
  output logic                          bus_wait_r,
  input  logic                          internal_osc_clock,
  input  logic                          hs_sys_clock,
  input  logic                          osc_clk_run,
  input  logic                          hs_clk_run,
  input  logic                          halt_mode,
  input  logic                          stop_mode,
  input  logic                          option_nonstop,
  input  logic                          cause_flag_clr,
  output logic                          watchdog_reset_r,
  output logic                          watchdog_reset_cause_flag_r
);

  import plwd_pkg::*;

  // ---------------------------------------------------------------------
  // Period decode
  // ---------------------------------------------------------------------

  // Last counter value before overflow: 2^(base+n) - 1.
  function automatic logic [CNT_W-1:0] period_last(
    input logic [PER_MSB:0] n,
    input logic             hs
  );
    logic [4:0]     e;
    logic [CNT_W:0] p;
    e = (hs ? HS_EXP_BASE : OSC_EXP_BASE) + {2'h0, n};
    p = {{CNT_W{1'b0}}, 1'b1} << e;
    return CNT_W'(p - {{CNT_W{1'b0}}, 1'b1});
  endfunction

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  logic [DATA_W-1:0] mode_r;          // Mode select register.
  logic [DATA_W-1:0] mode_nxt;        // Next mode value.
  logic              lock_r;          // Set once the one write is used.
  logic              opt_nonstop_r;   // Captured option: cannot be stopped.
  logic              opt_taken_r;     // Option has been captured.
  logic [CNT_W-1:0]  cnt_r;           // Watchdog counter.
  logic [CNT_W-1:0]  cnt_nxt;         // Next counter value.
  plwd_state_t       state_r;         // Violation state.
  plwd_state_t       state_nxt;       // Next violation state.
  logic              cause_nxt;       // Next cause flag.
  logic [DATA_W-1:0] rdata_nxt;       // Next read data.
  logic              osc_rise;        // Synchronised oscillator edge.
  logic              hs_rise;         // Synchronised high-speed edge.

  // ---------------------------------------------------------------------
  // Source clock synchronisers
  // ---------------------------------------------------------------------

  // Both source clocks are far slower than mclk and are counted as
  // sampled edges; this keeps the block in one clock domain.
  plwd_edge_sync u_osc_sync (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .async_in (internal_osc_clock),
    .rise_r   (osc_rise)
  );

  plwd_edge_sync u_hs_sync (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .async_in (hs_sys_clock),
    .rise_r   (hs_rise)
  );

  // ---------------------------------------------------------------------
  // Access decode
  // ---------------------------------------------------------------------
  wire hit_mode   = (bus_addr == MODE_ADDR);   // Mode address selected.
  wire hit_key    = (bus_addr == KEY_ADDR);    // Key address selected.
  // A bit write to the mode register is simply ignored.
  wire mode_wr    = bus_wr && hit_mode && !bus_bit_op;
  wire mode_first = mode_wr && !lock_r;        // The one accepted write.
  wire mode_again = mode_wr && lock_r;         // Second write.
  wire key_bit    = (bus_wr || bus_rd) && hit_key && bus_bit_op;
  wire key_wr8    = bus_wr && hit_key && !bus_bit_op;
  wire key_clear  = key_wr8 && (bus_wdata == KEY_CLEAR);
  wire key_bad    = (key_wr8 && (bus_wdata != KEY_CLEAR)) || key_bit;

  // ---------------------------------------------------------------------
  // Clock selection and suspension
  // ---------------------------------------------------------------------

  // Stop bit only has effect in stoppable mode; the lock keeps it from
  // ever being cleared again, so a stop is permanent until reset.
  wire cs_stopped = !opt_nonstop_r && mode_r[CS_STOP_BIT];
  wire sel_hs     = !opt_nonstop_r && !mode_r[CS_STOP_BIT]
                    && mode_r[CS_SRC_BIT];
  // Standby suspends counting only in stoppable mode.
  wire suspend    = !opt_nonstop_r && (halt_mode || stop_mode);
  // In non-stop mode the oscillator cannot be stopped at all.
  wire src_run    = opt_nonstop_r ? 1'b1
                                  : (sel_hs ? hs_clk_run : osc_clk_run);
  wire src_avail  = src_run && !suspend && !cs_stopped;
  wire tick       = src_avail && (sel_hs ? hs_rise : osc_rise);

  // ---------------------------------------------------------------------
  // Counter control
  // ---------------------------------------------------------------------
  wire [CNT_W-1:0] cnt_last = period_last(mode_r[PER_MSB:0], sel_hs);
  wire             at_last  = (cnt_r == cnt_last);
  wire             cnt_clr  = mode_first || key_clear;
  // Violations are ignored entirely while stopped by the stop bit.
  wire             viol     = (mode_again || key_bad) && !cs_stopped;
  wire             overflow = tick && at_last && !cnt_clr;

  // New mode value; non-stop mode forces the fixed and clock bits.
  wire [DATA_W-1:0] mode_wval = opt_nonstop_r
      ? {FIX_BITS, 2'h0, bus_wdata[PER_MSB:0]}
      : bus_wdata;

  // Mode register next value: loaded only by the first full write.
  always_comb begin
    mode_nxt = mode_r;
    if (mode_first) begin
      mode_nxt = mode_wval;
    end
  end

  // Counter: clears win over ticks; it freezes once a reset is pending.
  always_comb begin
    cnt_nxt = cnt_r;
    if (cnt_clr) begin
      cnt_nxt = CNT_RST;
    end else if (tick && (state_r == WD_RUN) && !at_last) begin
      cnt_nxt = cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // ---------------------------------------------------------------------
  // Violation state machine
  // ---------------------------------------------------------------------

  // A violation while the source is stalled is remembered and fires as
  // soon as the source runs again; a reset, once issued, holds.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      WD_RUN: begin
        if (viol) begin
          state_nxt = src_avail ? WD_RESET : WD_PEND;
        end else if (overflow) begin
          state_nxt = WD_RESET;
        end
      end
      WD_PEND: begin
        if (src_avail) begin
          state_nxt = WD_RESET;
        end
      end
      WD_RESET: begin
        state_nxt = WD_RESET;
      end
    endcase
  end

  // Cause flag: the set wins over a clear in the same cycle.
  always_comb begin
    cause_nxt = watchdog_reset_cause_flag_r;
    if ((state_nxt == WD_RESET) && (state_r != WD_RESET)) begin
      cause_nxt = 1'b1;
    end else if (cause_flag_clr) begin
      cause_nxt = 1'b0;
    end
  end

  // Read data: the key register never shows the written value.
  always_comb begin
    rdata_nxt = bus_rdata_r;
    if (bus_rd) begin
      rdata_nxt = hit_mode ? mode_r : (hit_key ? KEY_READ : RDATA_RST);
    end
  end

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------

  // Option capture once after release; the pin must be static.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      opt_nonstop_r <= 1'b1;
      opt_taken_r   <= 1'b0;
    end else if (!opt_taken_r) begin
      opt_nonstop_r <= option_nonstop;
      opt_taken_r   <= 1'b1;
    end
  end

  // Mode, lock and counter; reset restores the single write.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mode_r <= MODE_RST;
      lock_r <= 1'b0;
      cnt_r  <= CNT_RST;
    end else begin
      mode_r <= mode_nxt;
      lock_r <= lock_r || mode_first;
      cnt_r  <= cnt_nxt;
    end
  end

  // Reset output and cause flag.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_r                     <= WD_RUN;
      watchdog_reset_r            <= 1'b0;
      watchdog_reset_cause_flag_r <= 1'b0;
    end else begin
      state_r                     <= state_nxt;
      watchdog_reset_r            <= (state_nxt == WD_RESET);
      watchdog_reset_cause_flag_r <= cause_nxt;
    end
  end

  // Bus answers; any full mode write costs one wait cycle.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bus_rdata_r <= RDATA_RST;
      bus_wait_r  <= 1'b0;
    end else begin
      bus_rdata_r <= rdata_nxt;
      bus_wait_r  <= mode_wr;
    end
  end

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  AST_MODE_AT_RESET: assert property (
    @(posedge mclk) disable iff (!arst_n)
    !lock_r |-> (mode_r == MODE_RST))
    else $error("Mode register left reset value without a write.");

  AST_SECOND_WRITE: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (mode_again && !cs_stopped && src_avail) |=> watchdog_reset_r)
    else $error("Second mode write did not assert reset.");

  AST_NONSTOP_OSC: assert property (
    @(posedge mclk) disable iff (!arst_n)
    opt_nonstop_r |-> (mode_r[CS_STOP_BIT:CS_SRC_BIT] == 2'h0) && !sel_hs)
    else $error("Non-stop mode left the internal oscillator.");

  AST_WAIT_CYCLE: assert property (
    @(posedge mclk) disable iff (!arst_n)
    mode_wr |=> bus_wait_r ##1 (!bus_wait_r || $past(mode_wr)))
    else $error("Mode write wait cycle wrong.");

  AST_KEY_CLEAR: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (key_clear || mode_first) |=> (cnt_r == CNT_RST))
    else $error("Counter not cleared by key or mode write.");

  AST_KEY_READ: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (bus_rd && hit_key) |=> (bus_rdata_r == KEY_READ))
    else $error("Key register did not read the fixed value.");

  AST_BAD_KEY: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (key_bad && !cs_stopped && src_avail) |=> watchdog_reset_r)
    else $error("Bad key access did not assert reset.");

  AST_OVERFLOW: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (tick && (cnt_r == period_last(mode_r[PER_MSB:0], sel_hs))
     && !cnt_clr) |=> watchdog_reset_r)
    else $error("Overflow did not assert reset.");

  AST_STOPPED_QUIET: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (cs_stopped && (state_r == WD_RUN)) |=>
      (state_r == WD_RUN) && cs_stopped && $stable(cnt_r))
    else $error("Stopped watchdog reset or restarted.");

  AST_PEND_FIRE: assert property (
    @(posedge mclk) disable iff (!arst_n)
    ((state_r == WD_PEND) && src_avail) |=> watchdog_reset_r)
    else $error("Pending violation did not fire on resume.");

  AST_CAUSE_SET: assert property (
    @(posedge mclk) disable iff (!arst_n)
    $rose(watchdog_reset_r) |-> watchdog_reset_cause_flag_r)
    else $error("Reset cause flag not set with watchdog reset.");

  AST_SUSPEND_HOLD: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (suspend && !cnt_clr) |=> $stable(cnt_r))
    else $error("Counter moved while suspended.");

endmodule

// ===== plwd_pkg.sv
package plwd_pkg;

  // ---------------------------------------------------------------------
  // Bus and datapath widths
  // ---------------------------------------------------------------------
  localparam int ADDR_W = 16;  // CPU address width.
  localparam int DATA_W = 8;   // CPU data width.
  localparam int CNT_W  = 20;  // Enough for the longest period, 2^20 ticks.

  // ---------------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] MODE_ADDR = 16'hFF98;  // Mode select.
  localparam logic [ADDR_W-1:0] KEY_ADDR  = 16'hFF99;  // Clear key.

  // ---------------------------------------------------------------------
  // Reset values and key codes
  // ---------------------------------------------------------------------
  localparam logic [DATA_W-1:0] MODE_RST  = 8'h67;  // Osc clock, max period.
  localparam logic [DATA_W-1:0] KEY_READ  = 8'h9A;  // Fixed key read value.
  localparam logic [DATA_W-1:0] KEY_CLEAR = 8'hAC;  // Only legal key write.
  localparam logic [DATA_W-1:0] RDATA_RST = 8'h00;  // Read data after reset.
  localparam logic [CNT_W-1:0]  CNT_RST   = 20'h00000;  // Counter at reset.

  // ---------------------------------------------------------------------
  // Mode register field layout
  // ---------------------------------------------------------------------
  localparam int CS_STOP_BIT = 4;  // Clock stop bit.
  localparam int CS_SRC_BIT  = 3;  // Clock source bit.
  localparam int PER_MSB     = 2;  // Period field is bits PER_MSB..0.
  localparam int FIX_MSB     = 7;  // Fixed field upper bit.
  localparam int FIX_LSB     = 5;  // Fixed field lower bit.
  localparam logic [2:0] FIX_BITS = 3'h3;  // Bits 7..5 forced to 0,1,1 in non-stop mode.

  // ---------------------------------------------------------------------
  // Overflow exponents: period is 2^(base + n) source ticks
  // ---------------------------------------------------------------------
  localparam logic [4:0] OSC_EXP_BASE = 5'h0B;  // Internal oscillator.
  localparam logic [4:0] HS_EXP_BASE  = 5'h0D;  // High-speed system clock.

  // ---------------------------------------------------------------------
  // Violation state
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    WD_RUN,    // Normal operation.
    WD_PEND,   // Violation seen while source clock stopped.
    WD_RESET   // Internal reset asserted until chip reset.
  } plwd_state_t;

endpackage

// ===== plwd_edge_sync.sv
`timescale 1ns/1ps

// -----------------------------------------------------------------------
// Three-stage synchroniser with rising-edge pulse
// -----------------------------------------------------------------------
module plwd_edge_sync (
  input  logic mclk,
  input  logic arst_n,
  input  logic async_in,
  output logic rise_r
);

  logic s1_r;   // First stage, read only by the second.
  logic s2_r;   // Second stage.
  logic s3_r;   // Third stage.
  logic lvl_r;  // Level accepted once second and third stages agree.

  // Shift chain; the accepted level only moves when the last two stages
  // agree, which filters a single metastable sample.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s1_r   <= 1'b0;
      s2_r   <= 1'b0;
      s3_r   <= 1'b0;
      lvl_r  <= 1'b0;
      rise_r <= 1'b0;
    end else begin
      s1_r   <= async_in;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      lvl_r  <= (s2_r == s3_r) ? s3_r : lvl_r;
      rise_r <= (s2_r == s3_r) && s3_r && !lvl_r;
    end
  end

endmodule

// ===== plwd_top_tb.sv
`timescale 1ns/1ps

module plwd_top_tb;
  import plwd_pkg::*;

  // ---------------------------------------------------------------------
  // Compare helper: counts every check and reports each mismatch.
  // ---------------------------------------------------------------------
  `define CHK(got, exp) \
    begin \
      compares++; \
      if ((got) !== (exp)) begin \
        bad_count++; \
        $display("[ERR] %0t got %h expected %h", $time, got, exp); \
      end \
    end

  // ---------------------------------------------------------------------
  // Stimulus and observation signals
  // ---------------------------------------------------------------------
  logic              mclk                        = 1'b0;   // Core clock.
  logic              arst_n                      = 1'b0;   // Chip reset.
  logic [ADDR_W-1:0] bus_addr                    = 16'h0000;  // Address.
  logic              bus_wr                      = 1'b0;   // Write strobe.
  logic              bus_rd                      = 1'b0;   // Read strobe.
  logic              bus_bit_op                  = 1'b0;   // Bit access.
  logic [DATA_W-1:0] bus_wdata                   = 8'h00;  // Write data.
  logic [DATA_W-1:0] bus_rdata_r;                          // Read data.
  logic              bus_wait_r;                           // Wait flag.
  logic              internal_osc_clock          = 1'b1;   // Osc source.
  logic              hs_sys_clock                = 1'b1;   // Fast source.
  logic              osc_clk_run                 = 1'b1;   // Osc running.
  logic              hs_clk_run                  = 1'b1;   // Fast running.
  logic              halt_mode                   = 1'b0;   // CPU halted.
  logic              stop_mode                   = 1'b0;   // CPU stopped.
  logic              option_nonstop              = 1'b0;   // Strap.
  logic              cause_flag_clr              = 1'b0;   // Flag clear.
  logic              watchdog_reset_r;                     // Reset request.
  logic              watchdog_reset_cause_flag_r;          // Cause flag.
  int                bad_count                   = 0;      // Mismatches.
  int                compares                    = 0;      // Checks made.

  // ---------------------------------------------------------------------
  // Device under test
  // ---------------------------------------------------------------------
  plwd_top uut (
    .mclk                        (mclk),
    .arst_n                      (arst_n),
    .bus_addr                    (bus_addr),
    .bus_wr                      (bus_wr),
    .bus_rd                      (bus_rd),
    .bus_bit_op                  (bus_bit_op),
    .bus_wdata                   (bus_wdata),
    .bus_rdata_r                 (bus_rdata_r),
    .bus_wait_r                  (bus_wait_r),
    .internal_osc_clock          (internal_osc_clock),
    .hs_sys_clock                (hs_sys_clock),
    .osc_clk_run                 (osc_clk_run),
    .hs_clk_run                  (hs_clk_run),
    .halt_mode                   (halt_mode),
    .stop_mode                   (stop_mode),
    .option_nonstop              (option_nonstop),
    .cause_flag_clr              (cause_flag_clr),
    .watchdog_reset_r            (watchdog_reset_r),
    .watchdog_reset_cause_flag_r (watchdog_reset_cause_flag_r)
  );

  // ---------------------------------------------------------------------
  // Clocks
  // ---------------------------------------------------------------------
  // Core clock at 200 MHz.
  always #2.5 mclk = ~mclk;
  // Both sources run at a fifth of the core rate, which stays safely
  // inside the synchroniser limit while keeping long periods short.
  // Both start high, so their rising edges land on falling core edges.
  always #12.5 internal_osc_clock = ~internal_osc_clock;
  always #12.5 hs_sys_clock = ~hs_sys_clock;

  // ---------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------
  // Chip reset for four cycles; the strap is set while reset is held.
  task automatic do_reset(input logic opt);
    option_nonstop = opt;
    osc_clk_run = 1'b1;
    halt_mode = 1'b0;
    stop_mode = 1'b0;
    arst_n = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    arst_n = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  // One bus access; it returns just after the taking edge, where the
  // answer of the device is already visible.
  task automatic acc(input logic [ADDR_W-1:0] a, input logic wr,
                     input logic bo, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    #1;
    bus_addr = a;
    bus_wr = wr;
    bus_rd = ~wr;
    bus_bit_op = bo;
    bus_wdata = d;
    @(posedge mclk);
    #1;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_bit_op = 1'b0;
  endtask

  // Waits for a number of source rises, then for the synchroniser.
  task automatic ticks(input int n, input logic hs);
    repeat (n) begin
      if (hs) @(posedge hs_sys_clock);
      else @(posedge internal_osc_clock);
    end
    repeat (6) @(posedge mclk);
    #1;
  endtask

  // Prints the totals and the verdict, then ends the run.
  task automatic conclude;
    $display("Mismatches %0d, comparisons %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ---------------------------------------------------------------------
  // Hang guard: the tests need about 430 us of source clock edges.
  // ---------------------------------------------------------------------
  initial begin
    #480000;
    bad_count++;
    $display("[ERR] %0t watchdog of the bench expired", $time);
    conclude();
  end

  // ---------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------
  initial begin
    // Reset values, read-only key, bit access and one-time write lock.
    do_reset(1'b0);
    `CHK(watchdog_reset_cause_flag_r, 1'b0)
    acc(MODE_ADDR, 1'b0, 1'b0, 8'h00);
    `CHK(bus_rdata_r, 8'h67)
    acc(KEY_ADDR, 1'b0, 1'b0, 8'h00);
    `CHK(bus_rdata_r, 8'h9A)
    acc(16'h0000, 1'b0, 1'b0, 8'h00);
    `CHK(bus_rdata_r, 8'h00)
    acc(MODE_ADDR, 1'b1, 1'b1, 8'h60);
    `CHK(bus_wait_r, 1'b0)
    acc(MODE_ADDR, 1'b0, 1'b0, 8'h00);
    `CHK(bus_rdata_r, 8'h67)
    acc(KEY_ADDR, 1'b1, 1'b0, KEY_CLEAR);
    acc(KEY_ADDR, 1'b0, 1'b0, 8'h00);
    `CHK(bus_rdata_r, 8'h9A)
    `CHK(watchdog_reset_r, 1'b0)
    // The fixed bits 7:5 are always written as 0, 1, 1.
    acc(MODE_ADDR, 1'b1, 1'b0, 8'h63);
    `CHK(bus_wait_r, 1'b1)
    @(posedge mclk);
    #1;
    `CHK(bus_wait_r, 1'b0)
    acc(MODE_ADDR, 1'b0, 1'b0, 8'h00);
    `CHK(bus_rdata_r, 8'h63)
    acc(MODE_ADDR, 1'b1, 1'b0, 8'h63);
    `CHK(watchdog_reset_r, 1'b1)
    `CHK(watchdog_reset_cause_flag_r, 1'b1)
    // The flag clears while the reset request still stands.
    cause_flag_clr = 1'b1;
    @(posedge mclk);
    #1;
    cause_flag_clr = 1'b0;
    `CHK(watchdog_reset_cause_flag_r, 1'b0)
    `CHK(watchdog_reset_r, 1'b1)

    // Clear key and HALT/STOP pause on the oscillator, shortest period.
    do_reset(1'b0);
    acc(MODE_ADDR, 1'b1, 1'b0, 8'h60);
    ticks(1200, 1'b0);
    acc(KEY_ADDR, 1'b1, 1'b0, KEY_CLEAR);
    ticks(1000, 1'b0);
    halt_mode = 1'b1;
    ticks(750, 1'b0);
    halt_mode = 1'b0;
    stop_mode = 1'b1;
    ticks(750, 1'b0);
    stop_mode = 1'b0;
    ticks(1030, 1'b0);
    `CHK(watchdog_reset_r, 1'b0)
    ticks(25, 1'b0);
    `CHK(watchdog_reset_r, 1'b1)

    // High-speed source, shortest period of 2^13 ticks.
    do_reset(1'b0);
    acc(MODE_ADDR, 1'b1, 1'b0, 8'h68);
    ticks(8170, 1'b1);
    `CHK(watchdog_reset_r, 1'b0)
    ticks(30, 1'b1);
    `CHK(watchdog_reset_r, 1'b1)

    // Wrong key value and a bit access to the key register.
    do_reset(1'b0);
    acc(KEY_ADDR, 1'b1, 1'b0, 8'h00);
    `CHK(watchdog_reset_r, 1'b1)
    `CHK(watchdog_reset_cause_flag_r, 1'b1)
    do_reset(1'b0);
    acc(KEY_ADDR, 1'b0, 1'b1, 8'h00);
    `CHK(watchdog_reset_r, 1'b1)

    // A violation while the source is stopped fires on its return.
    do_reset(1'b0);
    osc_clk_run = 1'b0;
    acc(KEY_ADDR, 1'b1, 1'b0, 8'h55);
    repeat (20) @(posedge mclk);
    #1;
    `CHK(watchdog_reset_r, 1'b0)
    osc_clk_run = 1'b1;
    ticks(4, 1'b0);
    `CHK(watchdog_reset_r, 1'b1)

    // Stopped through the stop bit: violations are silent, no restart.
    do_reset(1'b0);
    acc(MODE_ADDR, 1'b1, 1'b0, 8'h70);
    acc(KEY_ADDR, 1'b1, 1'b0, 8'h00);
    acc(KEY_ADDR, 1'b0, 1'b1, 8'h00);
    acc(MODE_ADDR, 1'b1, 1'b0, 8'h60);
    `CHK(watchdog_reset_r, 1'b0)
    acc(MODE_ADDR, 1'b0, 1'b0, 8'h00);
    `CHK(bus_rdata_r, 8'h70)
    ticks(2100, 1'b0);
    `CHK(watchdog_reset_r, 1'b0)

    // Non-stop strap: clock select ignored, counting through STOP.
    do_reset(1'b1);
    // The strap is dropped after capture; the block must not notice.
    option_nonstop = 1'b0;
    acc(MODE_ADDR, 1'b1, 1'b0, 8'h70);
    acc(MODE_ADDR, 1'b0, 1'b0, 8'h00);
    `CHK(bus_rdata_r, 8'h60)
    halt_mode = 1'b1;
    stop_mode = 1'b1;
    ticks(2030, 1'b0);
    `CHK(watchdog_reset_r, 1'b0)
    ticks(30, 1'b0);
    `CHK(watchdog_reset_r, 1'b1)
    conclude();
  end

endmodule
